// file: verilog/lincfg_pkg.sv
// lincfg_pkg: register map, field positions and timing for the LIN test configuration block
package lincfg_pkg;
    // ---------------------------------------------
    // register byte offsets
    // ---------------------------------------------
    localparam logic [4:0] CFG_OFS    = 5'h00;
    localparam logic [4:0] RXDATA_OFS = 5'h04;
    localparam logic [4:0] TXDATA_OFS = 5'h08;
    localparam logic [4:0] STATUS_OFS = 5'h14;
    // ---------------------------------------------
    // configuration fields
    // ---------------------------------------------
    localparam int AB_EN_BIT    = 3;
    localparam int THR_LSB      = 16;
    localparam int RX_START_BIT = 20;
    localparam int RX_INV_BIT   = 21;
    localparam int TX_START_BIT = 22;
    localparam int TX_INV_BIT   = 23;
    localparam int FRAME_OV_BIT = 24;
    localparam int UNLOCK_BIT   = 25;
    localparam logic [31:0] CFG_RW_MASK = 32'h03AF_FFFF;
    localparam logic [31:0] CFG_RESET   = 32'h0000_0000;
    // ---------------------------------------------
    // transmit data and status fields
    // ---------------------------------------------
    localparam int TXD_START_BIT = 8;
    localparam int TXD_STOP_BIT  = 9;
    localparam int ST_BREAK_BIT  = 0;
    localparam int ST_TXBUSY_BIT = 1;
    localparam int ST_RXBUSY_BIT = 2;
    localparam int ST_RXDONE_BIT = 3;
    localparam logic [3:0] HALF_WORD_BE = 4'h3;
    localparam logic DEF_START = 1'b0;
    localparam logic DEF_STOP  = 1'b1;
    // ---------------------------------------------
    // timing
    // ---------------------------------------------
    localparam int CLK_PERIOD_NS = 25;
    localparam int BIT_TIME_NS   = 52083;
    localparam int BIT_CYCLES    = BIT_TIME_NS / CLK_PERIOD_NS;
    localparam int BRK_BITS      = 11;
    localparam int FRAME_BITS    = 10;

    typedef struct packed {
        logic [7:0] data;
        logic       start_bit;
        logic       stop_bit;
    } lincfg_txreq_s;
endpackage

// file: verilog/lincfg_tx.sv
// lincfg_tx: serialiser for one byte field with caller-supplied start and stop bits
module lincfg_tx #(
    parameter int BIT_CYC = lincfg_pkg::BIT_CYCLES
) (
    input  wire logic                     sys_clk,
    input  wire logic                     nrst,
    input  wire logic                     go,
    input  wire lincfg_pkg::lincfg_txreq_s req,
    output logic                          busy,
    output logic                          line
);
    logic [9:0]  shift_r, shift_nxt;
    logic [3:0]  bits_r,  bits_nxt;
    logic [15:0] tick_r,  tick_nxt;
    logic        busy_r,  busy_nxt;
    logic        line_r,  line_nxt;

    always_comb
    begin
        shift_nxt = shift_r;
        bits_nxt  = bits_r;
        tick_nxt  = tick_r;
        busy_nxt  = busy_r;
        line_nxt  = line_r;
        if (!busy_r)
        begin
            line_nxt = 1'b1;
            if (go)
            begin
                shift_nxt = {req.stop_bit, req.data, req.start_bit};
                bits_nxt  = 4'h0;
                tick_nxt  = 16'(BIT_CYC - 1);
                busy_nxt  = 1'b1;
                line_nxt  = req.start_bit;
            end
        end
        else if (tick_r != 16'h0000)
            tick_nxt = tick_r - 16'h0001;
        else if (bits_r == 4'(lincfg_pkg::FRAME_BITS - 1))
        begin
            busy_nxt = 1'b0;
            line_nxt = 1'b1;
        end
        else
        begin
            shift_nxt = {1'b1, shift_r[9:1]};
            bits_nxt  = bits_r + 4'h1;
            tick_nxt  = 16'(BIT_CYC - 1);
            line_nxt  = shift_r[1];
        end
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            shift_r <= 10'h3FF;
            bits_r  <= 4'h0;
            tick_r  <= 16'h0000;
            busy_r  <= 1'b0;
            line_r  <= 1'b1;
        end
        else
        begin
            shift_r <= shift_nxt;
            bits_r  <= bits_nxt;
            tick_r  <= tick_nxt;
            busy_r  <= busy_nxt;
            line_r  <= line_nxt;
        end
    end

    assign busy = busy_r;
    assign line = line_r;
endmodule

// file: verilog/lincfg_top.sv
// lincfg_top: Avalon-MM slave with the LIN test configuration, autobaud break check and paths
//
// The Avalon-MM register port and the register offsets were left to the implementer.
module lincfg_top #(
    parameter int BIT_CYC = lincfg_pkg::BIT_CYCLES
) (
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    input  wire logic [4:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic [31:0]      readdata,
    output logic             waitrequest,
    input  wire logic        bus_receive_pin,
    output logic             bus_transmit_pin
);
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} lincfg_rx_e;

    // ---------------------------------------------
    // bus slave and registers
    // ---------------------------------------------
    logic [31:0] cfg_r, cfg_nxt, rdata_r, rdata_nxt, be_mask;
    logic        wait_r, wait_nxt, tx_go_r, tx_go_nxt, rx_armed_r, rx_armed_nxt;
    logic [7:0]  txd_r, txd_nxt;
    logic        txd_start_r, txd_start_nxt, txd_stop_r, txd_stop_nxt;
    logic        brk_r, brk_nxt, rxdone_r, rxdone_nxt, pin_r;
    logic        wr_acc, rd_acc, tx_busy, tx_line, rx_val, brk_evt, rx_fin;
    logic [31:0] status_w, rxdata_w;
    lincfg_pkg::lincfg_txreq_s tx_req;

    // receiver and break-measurement state
    lincfg_rx_e  rx_st_r, rx_st_nxt;
    logic [15:0] rx_tick_r, rx_tick_nxt;
    logic [3:0]  rx_bits_r, rx_bits_nxt;
    logic [9:0]  rx_sh_r, rx_sh_nxt;
    logic [9:0]  rx_word_r, rx_word_nxt;
    logic        rx_prev_r, rx_sync_r;
    logic [19:0] low_cnt_r, low_cnt_nxt, thresh, base, delta;

    assign wr_acc = write && !wait_r;
    assign rd_acc = read && !wait_r;
    assign be_mask = {{8{byteenable[3]}}, {8{byteenable[2]}},
                      {8{byteenable[1]}}, {8{byteenable[0]}}};
    assign rx_val = bus_receive_pin ^ cfg_r[lincfg_pkg::RX_INV_BIT];
    assign rxdata_w = {21'h000000, rx_sync_r, rx_word_r};
    assign status_w = {28'h0000000, rxdone_r, (rx_st_r != RX_IDLE), tx_busy, brk_r};

    // ---------------------------------------------
    // autobaud threshold
    // ---------------------------------------------
    always_comb
    begin
        base  = 20'(lincfg_pkg::BRK_BITS * BIT_CYC);
        delta = 20'h00000;
        case (cfg_r[lincfg_pkg::THR_LSB +: 3])
            3'h1: delta = base >> 7;
            3'h2: delta = base >> 6;
            3'h3: delta = base >> 5;
            3'h4: delta = base >> 4;
            default: delta = 20'h00000;
        endcase
        if (cfg_r[lincfg_pkg::THR_LSB + 3])
            thresh = base - delta;
        else
            thresh = base + delta;
    end

    assign brk_evt = rx_val && !rx_prev_r && cfg_r[lincfg_pkg::AB_EN_BIT] && (low_cnt_r >= thresh);

    // ---------------------------------------------
    // register file next state
    // ---------------------------------------------
    always_comb
    begin
        cfg_nxt       = cfg_r;
        wait_nxt      = !((read || write) && wait_r);
        rdata_nxt     = rdata_r;
        tx_go_nxt     = 1'b0;
        rx_armed_nxt  = rx_armed_r;
        txd_nxt       = txd_r;
        txd_start_nxt = txd_start_r;
        txd_stop_nxt  = txd_stop_r;
        brk_nxt       = brk_r;
        rxdone_nxt    = rxdone_r;
        if (read && wait_r)
        begin
            if (address == lincfg_pkg::CFG_OFS)
                rdata_nxt = cfg_r & lincfg_pkg::CFG_RW_MASK;
            else if (address == lincfg_pkg::RXDATA_OFS)
                rdata_nxt = rxdata_w;
            else if (address == lincfg_pkg::STATUS_OFS)
                rdata_nxt = status_w;
            else
                rdata_nxt = 32'h0000_0000;
        end
        if (wr_acc && address == lincfg_pkg::CFG_OFS)
        begin
            cfg_nxt = (cfg_r & ~be_mask) | (writedata & be_mask & lincfg_pkg::CFG_RW_MASK);
            if (byteenable[2] && writedata[lincfg_pkg::RX_START_BIT])
                rx_armed_nxt = 1'b1;
            if (byteenable[2] && writedata[lincfg_pkg::TX_START_BIT] && !tx_busy)
                tx_go_nxt = 1'b1;
        end
        if (wr_acc && address == lincfg_pkg::TXDATA_OFS)
        begin
            if (byteenable[0])
                txd_nxt = writedata[7:0];
            if (cfg_r[lincfg_pkg::UNLOCK_BIT] &&
                (byteenable & lincfg_pkg::HALF_WORD_BE) == lincfg_pkg::HALF_WORD_BE)
            begin
                txd_start_nxt = writedata[lincfg_pkg::TXD_START_BIT];
                txd_stop_nxt  = writedata[lincfg_pkg::TXD_STOP_BIT];
            end
            if (cfg_r[lincfg_pkg::UNLOCK_BIT] && !tx_busy)
                tx_go_nxt = 1'b1;
        end
        if (wr_acc && address == lincfg_pkg::STATUS_OFS && byteenable[0])
        begin
            if (writedata[lincfg_pkg::ST_BREAK_BIT])
                brk_nxt = 1'b0;
            if (writedata[lincfg_pkg::ST_RXDONE_BIT])
                rxdone_nxt = 1'b0;
        end
        if (brk_evt)
            brk_nxt = 1'b1;
        if (rx_fin)
        begin
            rxdone_nxt   = 1'b1;
            rx_armed_nxt = 1'b0;
        end
    end

    // default framing unless the override is set
    always_comb
    begin
        tx_req.data = txd_r;
        if (cfg_r[lincfg_pkg::FRAME_OV_BIT])
        begin
            tx_req.start_bit = txd_start_r;
            tx_req.stop_bit  = txd_stop_r;
        end
        else
        begin
            tx_req.start_bit = lincfg_pkg::DEF_START;
            tx_req.stop_bit  = lincfg_pkg::DEF_STOP;
        end
    end

    // ---------------------------------------------
    // receive sequencer and break measurement
    // ---------------------------------------------
    assign rx_fin = (rx_st_r == RX_STOP) && (rx_tick_r == 16'h0000);

    always_comb
    begin
        rx_st_nxt   = rx_st_r;
        rx_tick_nxt = rx_tick_r;
        rx_bits_nxt = rx_bits_r;
        rx_sh_nxt   = rx_sh_r;
        rx_word_nxt = rx_word_r;
        low_cnt_nxt = rx_val ? 20'h00000 : ((low_cnt_r == 20'hFFFFF) ? low_cnt_r
                                                                    : low_cnt_r + 20'h00001);
        if (rx_tick_r != 16'h0000)
            rx_tick_nxt = rx_tick_r - 16'h0001;
        case (rx_st_r)
            RX_IDLE:
                if ((rx_armed_r || cfg_r[lincfg_pkg::UNLOCK_BIT]) && rx_prev_r && !rx_val)
                begin
                    rx_st_nxt   = RX_START;
                    rx_tick_nxt = 16'((BIT_CYC / 2) - 1);
                    rx_bits_nxt = 4'h0;
                end
            RX_START:
                if (rx_tick_r == 16'h0000)
                begin
                    rx_sh_nxt   = {rx_val, rx_sh_r[9:1]};
                    rx_tick_nxt = 16'(BIT_CYC - 1);
                    rx_st_nxt   = RX_DATA;
                end
            RX_DATA:
                if (rx_tick_r == 16'h0000)
                begin
                    rx_sh_nxt   = {rx_val, rx_sh_r[9:1]};
                    rx_tick_nxt = 16'(BIT_CYC - 1);
                    rx_bits_nxt = rx_bits_r + 4'h1;
                    if (rx_bits_r == 4'h7)
                        rx_st_nxt = RX_STOP;
                end
            RX_STOP:
                if (rx_tick_r == 16'h0000)
                begin
                    rx_word_nxt = {rx_val, rx_sh_r[1], rx_sh_r[9:2]};
                    rx_st_nxt   = RX_IDLE;
                end
            default: rx_st_nxt = RX_IDLE;
        endcase
    end

    // ---------------------------------------------
    // registers
    // ---------------------------------------------
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cfg_r       <= lincfg_pkg::CFG_RESET;
            wait_r      <= 1'b1;
            rdata_r     <= 32'h0000_0000;
            tx_go_r     <= 1'b0;
            rx_armed_r  <= 1'b0;
            txd_r       <= 8'h00;
            txd_start_r <= 1'b0;
            txd_stop_r  <= 1'b0;
            brk_r       <= 1'b0;
            rxdone_r    <= 1'b0;
            pin_r       <= 1'b1;
            rx_st_r     <= RX_IDLE;
            rx_tick_r   <= 16'h0000;
            rx_bits_r   <= 4'h0;
            rx_sh_r     <= 10'h000;
            rx_word_r   <= 10'h000;
            rx_prev_r   <= 1'b1;
            rx_sync_r   <= 1'b0;
            low_cnt_r   <= 20'h00000;
        end
        else
        begin
            cfg_r       <= cfg_nxt;
            wait_r      <= wait_nxt;
            rdata_r     <= rdata_nxt;
            tx_go_r     <= tx_go_nxt;
            rx_armed_r  <= rx_armed_nxt;
            txd_r       <= txd_nxt;
            txd_start_r <= txd_start_nxt;
            txd_stop_r  <= txd_stop_nxt;
            brk_r       <= brk_nxt;
            rxdone_r    <= rxdone_nxt;
            pin_r       <= tx_line ^ cfg_r[lincfg_pkg::TX_INV_BIT];
            rx_st_r     <= rx_st_nxt;
            rx_tick_r   <= rx_tick_nxt;
            rx_bits_r   <= rx_bits_nxt;
            rx_sh_r     <= rx_sh_nxt;
            rx_word_r   <= rx_word_nxt;
            rx_prev_r   <= rx_val;
            rx_sync_r   <= rx_val;
            low_cnt_r   <= low_cnt_nxt;
        end
    end

    lincfg_tx #(.BIT_CYC(BIT_CYC)) u_tx (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .go      (tx_go_r),
        .req     (tx_req),
        .busy    (tx_busy),
        .line    (tx_line)
    );

    assign readdata         = rdata_r;
    assign waitrequest      = wait_r;
    assign bus_transmit_pin = pin_r;

    // ---------------------------------------------
    // assertions
    // ---------------------------------------------
    sequence s_tx_write;
        wr_acc && address == lincfg_pkg::TXDATA_OFS && cfg_r[lincfg_pkg::UNLOCK_BIT] && !tx_busy;
    endsequence
    sequence s_tx_launch;
        tx_go_r ##1 tx_busy;
    endsequence

    a_thr_nominal: assert property (@(posedge sys_clk) disable iff (!nrst)
        cfg_r[19:16] == 4'h0 |-> thresh == 20'(lincfg_pkg::BRK_BITS * BIT_CYC))
        else $error("nominal break threshold wrong");
    a_thr_minus: assert property (@(posedge sys_clk) disable iff (!nrst)
        cfg_r[19:16] == 4'hC |-> thresh == base - (base >> 4))
        else $error("shortest break threshold wrong");
    a_rxstart_rdzero: assert property (@(posedge sys_clk) disable iff (!nrst)
        !wait_r |-> !readdata[lincfg_pkg::RX_START_BIT])
        else $error("rx start strobe read back as one");
    a_rxstart_arms: assert property (@(posedge sys_clk) disable iff (!nrst)
        wr_acc && address == lincfg_pkg::CFG_OFS && byteenable[2] && writedata[20] && !rx_fin
        |=> rx_armed_r)
        else $error("rx start strobe did not arm receiver");
    a_rx_polarity: assert property (@(posedge sys_clk) disable iff (!nrst)
        $stable(cfg_r[21]) |=> rx_sync_r == ($past(bus_receive_pin) ^ $past(cfg_r[21])))
        else $error("receive polarity wrong");
    a_txstart_runs: assert property (@(posedge sys_clk) disable iff (!nrst)
        wr_acc && address == lincfg_pkg::CFG_OFS && byteenable[2] && writedata[22] && !tx_busy
        |=> s_tx_launch)
        else $error("tx start strobe did not launch transmitter");
    a_tx_polarity: assert property (@(posedge sys_clk) disable iff (!nrst)
        !tx_busy && !tx_go_r && $stable(cfg_r[23])
        |=> ##1 bus_transmit_pin == !$past(cfg_r[23]))
        else $error("idle transmit level ignores polarity");
    a_default_frame: assert property (@(posedge sys_clk) disable iff (!nrst)
        tx_go_r && !cfg_r[24] |-> !tx_req.start_bit && tx_req.stop_bit)
        else $error("default framing wrong");
    a_override_frame: assert property (@(posedge sys_clk) disable iff (!nrst)
        tx_go_r && cfg_r[24] |-> tx_req.start_bit == txd_start_r && tx_req.stop_bit == txd_stop_r)
        else $error("override framing wrong");
    a_unlock_launch: assert property (@(posedge sys_clk) disable iff (!nrst)
        s_tx_write |=> s_tx_launch)
        else $error("unlocked data write did not transmit");
    a_locked_frame: assert property (@(posedge sys_clk) disable iff (!nrst)
        wr_acc && address == lincfg_pkg::TXDATA_OFS && !cfg_r[25] |=> $stable(txd_start_r))
        else $error("start bit taken while locked");
endmodule

// file: bench/lincfg_node.sv
// lincfg_node: far LIN node that drives the receive pin and decodes the transmit pin
module lincfg_node #(
    parameter int BIT_CYC = 16
) (
    input  wire logic sys_clk,
    input  wire logic tx_pin,
    output logic      rx_pin
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------
    // line driving
    // ------------------------------
    // recessive idle level through the pull-up
    initial rx_pin = 1'b1;

    task automatic set_line(input logic v);
        @(posedge sys_clk);
        rx_pin <= v;
    endtask

    // byte field lsb first, then the idle level of the chosen polarity
    task automatic send_bits(input logic [9:0] bits, input logic inv);
        for (int i = 0; i < 10; i++)
        begin
            @(posedge sys_clk);
            rx_pin <= bits[i] ^ inv;
            repeat (BIT_CYC - 1) @(posedge sys_clk);
        end
        @(posedge sys_clk);
        rx_pin <= ~inv;
    endtask

    task automatic hold_low(input int n);
        @(posedge sys_clk);
        rx_pin <= 1'b0;
        repeat (n) @(posedge sys_clk);
        rx_pin <= 1'b1;
    endtask

    // ------------------------------
    // frame capture
    // ------------------------------
    // started at the accepting edge; samples each bit near its middle
    task automatic get_frame(input logic inv, output logic [9:0] bits);
        repeat (3 + BIT_CYC / 2) @(posedge sys_clk);
        for (int i = 0; i < 10; i++)
        begin
            bits[i] = tx_pin ^ inv;
            repeat (BIT_CYC) @(posedge sys_clk);
        end
    endtask
endmodule

// file: bench/lincfg_top_bench.sv
// lincfg_top_bench: register-level tests of the LIN test configuration block
module lincfg_top_bench;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int BC   = 128;
    localparam int BASE = 11 * BC;

    logic        sys_clk;
    logic        nrst;
    logic [4:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
    logic [31:0] readdata;
    logic        waitrequest;
    logic        rx_line;
    logic        tx_line;
    int          num_errors = 0;
    int          num_checks = 0;
    int          cycles     = 0;
    logic [31:0] rd;
    logic [9:0]  fr;
    int          thr;

    lincfg_top #(.BIT_CYC(BC)) DUT (
        .sys_clk          (sys_clk),
        .nrst             (nrst),
        .address          (address),
        .read             (read),
        .write            (write),
        .writedata        (writedata),
        .byteenable       (byteenable),
        .readdata         (readdata),
        .waitrequest      (waitrequest),
        .bus_receive_pin  (rx_line),
        .bus_transmit_pin (tx_line)
    );

    lincfg_node #(.BIT_CYC(BC)) node (
        .sys_clk (sys_clk),
        .tx_pin  (tx_line),
        .rx_pin  (rx_line)
    );

    initial
    begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    // ------------------------------
    // reporting
    // ------------------------------
    task automatic complete_run;
        if (num_errors == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] %0t got %08h exp %08h", $time, got, exp);
        end
    endtask

    task automatic chk_frame(input logic [9:0] got, input logic [9:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] %0t got %03h exp %03h", $time, got, exp);
        end
    endtask

    // hang guard
    always @(posedge sys_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 90000)
        begin
            num_errors++;
            complete_run();
        end
    end

    // ------------------------------
    // bus access
    // ------------------------------
    task automatic bus_write(input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
        @(posedge sys_clk);
        address    <= a;
        writedata  <= d;
        byteenable <= be;
        write      <= 1'b1;
        @(posedge sys_clk);
        while (waitrequest !== 1'b0) @(posedge sys_clk);
        write <= 1'b0;
    endtask

    task automatic bus_read(input logic [4:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        address <= a;
        read    <= 1'b1;
        @(posedge sys_clk);
        while (waitrequest !== 1'b0) @(posedge sys_clk);
        d = readdata;
        read <= 1'b0;
    endtask

    // poll one status bit until it reaches v
    task automatic wait_status(input int b, input logic v);
        for (int i = 0; i < 400; i++)
        begin
            bus_read(lincfg_pkg::STATUS_OFS, rd);
            if (rd[b] === v) break;
        end
    endtask

    function automatic int brk_thr(input logic [3:0] c);
        if (c >= 4'h1 && c <= 4'h4) return BASE + (BASE >> (8 - c));
        if (c >= 4'h9 && c <= 4'hC) return BASE - (BASE >> (16 - c));
        return BASE;
    endfunction

    // ------------------------------
    // test sequence
    // ------------------------------
    initial
    begin
        nrst       = 1'b0;
        address    = 5'h00;
        read       = 1'b0;
        write      = 1'b0;
        writedata  = 32'h0000_0000;
        byteenable = 4'h0;
        repeat (4) @(posedge sys_clk);
        nrst <= 1'b1;
        bus_read(lincfg_pkg::CFG_OFS, rd);
        chk_word(rd, lincfg_pkg::CFG_RESET);
        bus_read(lincfg_pkg::RXDATA_OFS, rd);
        chk_word(rd, 32'h0000_0400);
        bus_read(lincfg_pkg::TXDATA_OFS, rd);
        chk_word(rd, 32'h0000_0000);
        bus_read(5'h1C, rd);
        chk_word(rd, 32'h0000_0000);
        // storage, lanes and idle inversion
        bus_write(lincfg_pkg::CFG_OFS, 32'h038F_FFFF, 4'hF);
        bus_read(lincfg_pkg::CFG_OFS, rd);
        chk_word(rd, 32'h038F_FFFF);
        repeat (4) @(posedge sys_clk);
        chk_word({31'h0, tx_line}, 32'h0000_0000);
        bus_write(lincfg_pkg::CFG_OFS, 32'h0000_0000, 4'h3);
        bus_read(lincfg_pkg::CFG_OFS, rd);
        chk_word(rd, 32'h038F_0000);
        bus_write(lincfg_pkg::CFG_OFS, 32'h0000_0000, 4'hF);
        bus_read(lincfg_pkg::STATUS_OFS, rd);
        chk_word(rd, 32'h0000_0000);
        // locked: framing bits of the data write are not kept
        bus_write(lincfg_pkg::CFG_OFS, 32'h0100_0000, 4'hF);
        bus_write(lincfg_pkg::TXDATA_OFS, 32'h0000_03A5, 4'hF);
        bus_read(lincfg_pkg::STATUS_OFS, rd);
        chk_word(rd, 32'h0000_0000);
        bus_write(lincfg_pkg::CFG_OFS, 32'h0140_0000, 4'hF);
        node.get_frame(1'b0, fr);
        chk_frame(fr, {1'b0, 8'hA5, 1'b0});
        wait_status(lincfg_pkg::ST_TXBUSY_BIT, 1'b0);
        bus_read(lincfg_pkg::CFG_OFS, rd);
        chk_word(rd, 32'h0100_0000);
        // default framing
        bus_write(lincfg_pkg::CFG_OFS, 32'h0040_0000, 4'hF);
        node.get_frame(1'b0, fr);
        chk_frame(fr, {1'b1, 8'hA5, 1'b0});
        wait_status(lincfg_pkg::ST_TXBUSY_BIT, 1'b0);
        // unlocked: data write launches, framing from data bits with the override set, default framing without
        bus_write(lincfg_pkg::CFG_OFS, 32'h0300_0000, 4'hF);
        bus_write(lincfg_pkg::TXDATA_OFS, 32'h0000_013C, 4'hF);
        node.get_frame(1'b0, fr);
        chk_frame(fr, {1'b0, 8'h3C, 1'b1});
        wait_status(lincfg_pkg::ST_TXBUSY_BIT, 1'b0);
        bus_write(lincfg_pkg::CFG_OFS, 32'h0200_0000, 4'hF);
        bus_write(lincfg_pkg::TXDATA_OFS, 32'h0000_0066, 4'h1);
        node.get_frame(1'b0, fr);
        chk_frame(fr, {1'b1, 8'h66, 1'b0});
        wait_status(lincfg_pkg::ST_TXBUSY_BIT, 1'b0);
        // inverted transmit
        bus_write(lincfg_pkg::CFG_OFS, 32'h0080_0000, 4'hF);
        repeat (4) @(posedge sys_clk);
        chk_word({31'h0, tx_line}, 32'h0000_0000);
        bus_write(lincfg_pkg::CFG_OFS, 32'h00C0_0000, 4'hF);
        node.get_frame(1'b1, fr);
        chk_frame(fr, {1'b1, 8'h66, 1'b0});
        wait_status(lincfg_pkg::ST_TXBUSY_BIT, 1'b0);
        // receive, plain then inverted
        bus_write(lincfg_pkg::CFG_OFS, 32'h0010_0000, 4'hF);
        node.send_bits({1'b1, 8'h5A, 1'b0}, 1'b0);
        wait_status(lincfg_pkg::ST_RXDONE_BIT, 1'b1);
        bus_read(lincfg_pkg::RXDATA_OFS, rd);
        chk_word(rd, 32'h0000_065A);
        bus_write(lincfg_pkg::STATUS_OFS, 32'h0000_0009, 4'hF);
        bus_write(lincfg_pkg::CFG_OFS, 32'h0020_0000, 4'hF);
        node.set_line(1'b0);
        bus_write(lincfg_pkg::CFG_OFS, 32'h0030_0000, 4'hF);
        node.send_bits({1'b1, 8'hC3, 1'b0}, 1'b1);
        wait_status(lincfg_pkg::ST_RXDONE_BIT, 1'b1);
        bus_read(lincfg_pkg::RXDATA_OFS, rd);
        chk_word(rd, 32'h0000_06C3);
        bus_write(lincfg_pkg::CFG_OFS, 32'h0000_0000, 4'hF);
        node.set_line(1'b1);
        bus_write(lincfg_pkg::STATUS_OFS, 32'h0000_0009, 4'hF);
        // break threshold for every code, just below and just above
        for (int c = 0; c < 16; c++)
        begin
            thr = brk_thr(c[3:0]);
            bus_write(lincfg_pkg::CFG_OFS, {12'h000, c[3:0], 16'h0008}, 4'hF);
            node.hold_low(thr - 4);
            repeat (BC) @(posedge sys_clk);
            bus_read(lincfg_pkg::STATUS_OFS, rd);
            chk_word(rd & 32'h0000_0001, 32'h0000_0000);
            node.hold_low(thr + 4);
            repeat (BC) @(posedge sys_clk);
            bus_read(lincfg_pkg::STATUS_OFS, rd);
            chk_word(rd & 32'h0000_0001, 32'h0000_0001);
            bus_write(lincfg_pkg::STATUS_OFS, 32'h0000_0001, 4'hF);
        end
        complete_run();
    end
endmodule
